// *** src/cima_top.v ***
// Purpose: contact-input events turned into loop mode actions, two loops
// Assumes: AXI4-Lite master, contacts asynchronous to clk_sys_i
// Notes: each loop has a cfg, an assign and a status word
//
// What this block does
// - go-automatic trigger selects automatic
// - go-hand trigger selects operator hand
// - go-remote trigger selects remote, feature enabled only
// - go-local trigger selects local, feature enabled only
// - tuning input: rise starts, fall stops
// - acknowledge trigger issues one alarm acknowledge
// - PV switching by input: rise second, fall first
// - external PV replaces both analog inputs
// - setpoint bits decode 1..8; zero keeps group
// - setpoint value 9..15 or over count ignored
// - unassigned setpoint bits read as off
// - PID bits act only with external selection
// - PID bits decode 1..8; zero keeps group
// - PID value 9..15 or over count ignored
// - unassigned PID bits read as off
// - rising-edge mode acts once on off-to-on
// - falling-edge mode acts once on on-to-off, except group selects, whose bits then read zero
// - auto/hand input: rise automatic, fall hand
`timescale 1ns/10ps
`default_nettype none
`include "cima_defines.vh"
module cima_top #(
  parameter [23:0] CTRL_PERIOD_CYCLES = `CIMA_CTRL_PERIOD_CYCLES
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] loop_contact_i,
  output wire [1:0] auto_mode_o,
  output wire [1:0] remote_sel_o,
  output wire [1:0] tune_run_o,
  output wire [1:0] alarm_ack_o,
  output wire [1:0] second_analog_input_o,
  output wire [1:0] external_pv_input_o,
  output wire [7:0] setpoint_group_o,
  output wire [7:0] pid_group_o
);
  function [31:0] merge_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge_strb = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_strb[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // a decoded group is taken only if 1..8 and within the configured count
  function group_ok;
    input [3:0] val;
    input [3:0] cnt;
    begin
      group_ok = (val != 4'h0) && (val <= `CIMA_GROUP_MAX) && (val <= cnt);
    end
  endfunction

  function hit_addr;
    input [7:0] addr;
    begin
      hit_addr = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0) && (addr[3:2] != 2'h3);
    end
  endfunction

  // control period tick
  reg [23:0] per_cnt_q;
  reg tick_q;
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      per_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (per_cnt_q == CTRL_PERIOD_CYCLES - 24'h000001) begin
      per_cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      per_cnt_q <= per_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  wire [31:0] contact_sync;
  cima_sync #(.W(32)) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i(loop_contact_i),
    .sync_o(contact_sync)
  );

  // register bus: ready is raised one cycle after valid, one item held each
  reg awready_q;
  reg wready_q;
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_hit = do_wr & hit_addr(aw_addr_q);
  wire [31:0] cfg_w [0:1];
  wire [31:0] asg_w [0:1];
  wire [31:0] sts_w [0:1];

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CIMA_RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid_i & ~awready_q & ~aw_full_q & ~bvalid_q;
      wready_q <= s_axi_wvalid_i & ~wready_q & ~w_full_q & ~bvalid_q;
      if (s_axi_awvalid_i & awready_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & wready_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= hit_addr(aw_addr_q) ? `CIMA_RESP_OKAY : `CIMA_RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CIMA_RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid_i & ~arready_q & ~rvalid_q;
      if (s_axi_arvalid_i & arready_q) begin
        rvalid_q <= 1'b1;
        if (!hit_addr(s_axi_araddr_i)) begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `CIMA_RESP_SLVERR;
        end else begin
          rresp_q <= `CIMA_RESP_OKAY;
          case (s_axi_araddr_i[3:2])
            `CIMA_OFS_CFG: begin
              rdata_q <= cfg_w[s_axi_araddr_i[4]];
            end
            `CIMA_OFS_ASSIGN: begin
              rdata_q <= asg_w[s_axi_araddr_i[4]];
            end
            default: begin
              rdata_q <= sts_w[s_axi_araddr_i[4]];
            end
          endcase
        end
      end else if (rvalid_q & s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  genvar n;
  generate
    for (n = 0; n < `CIMA_NUM_LOOPS; n = n + 1) begin : g_loop
      reg [31:0] cfg_q;
      reg [31:0] asg_q;
      reg auto_q;
      reg remote_q;
      reg tune_q;
      reg ack_q;
      reg pv2_q;
      reg [3:0] sp_q;
      reg [3:0] pid_q;
      wire sel_me = wr_hit & (aw_addr_q[4] == n);
      // unassigned contacts read as constantly off
      wire [15:0] cont = contact_sync[n*16 +: 16] & asg_q[15:0];
      wire [3:0] sp_bits = cont[`CIMA_C_SP_LSB +: 4];
      wire [3:0] pid_bits = cont[`CIMA_C_PID_LSB +: 4];
      wire [17:0] lvl = {|pid_bits, |sp_bits, cont};
      wire [17:0] rise;
      wire [17:0] fall;
      wire [17:0] trig;
      wire [17:0] fire;
      wire [1:0] mode = cfg_q[`CIMA_F_OPMODE_LSB +: 2];
      wire rsp_en = cfg_q[`CIMA_F_RSP_EN];
      wire [3:0] sp_cnt = cfg_q[`CIMA_F_SP_CNT_LSB +: 4];
      wire [3:0] pid_cnt = cfg_q[`CIMA_F_PID_CNT_LSB +: 4];
      // the group value is read from the contacts as sampled this period
      reg [3:0] sp_val_q;
      reg [3:0] pid_val_q;

      cima_detect #(.W(18)) u_det (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .tick_i(tick_q),
        .level_i(lvl),
        .rise_o(rise),
        .fall_o(fall),
        .trig_o(trig)
      );

      assign fire = (mode == `CIMA_MODE_RISE) ? rise :
                    (mode == `CIMA_MODE_FALL) ? fall : trig;

      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          sp_val_q <= 4'h0;
          pid_val_q <= 4'h0;
        end else if (tick_q) begin
          sp_val_q <= sp_bits;
          pid_val_q <= pid_bits;
        end
      end

      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          cfg_q <= `CIMA_CFG_RST;
          asg_q <= `CIMA_ASSIGN_RST;
        end else if (sel_me & (aw_addr_q[3:2] == `CIMA_OFS_CFG)) begin
          cfg_q <= merge_strb(cfg_q, w_data_q, w_strb_q);
        end else if (sel_me & (aw_addr_q[3:2] == `CIMA_OFS_ASSIGN)) begin
          asg_q <= merge_strb(asg_q, w_data_q, w_strb_q);
        end
      end

      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          auto_q <= 1'b0;
          remote_q <= 1'b0;
          tune_q <= 1'b0;
          ack_q <= 1'b0;
          pv2_q <= 1'b0;
          sp_q <= `CIMA_GROUP_RST;
          pid_q <= `CIMA_GROUP_RST;
        end else begin
          // hand wins over automatic when both fire in one period, as the safer mode
          if (fire[`CIMA_C_HAND] | fall[`CIMA_C_AUTOHAND]) begin
            auto_q <= 1'b0;
          end else if (fire[`CIMA_C_AUTO] | rise[`CIMA_C_AUTOHAND]) begin
            auto_q <= 1'b1;
          end
          if (rsp_en & fire[`CIMA_C_LOCAL]) begin
            remote_q <= 1'b0;
          end else if (rsp_en & fire[`CIMA_C_REMOTE]) begin
            remote_q <= 1'b1;
          end
          if (rise[`CIMA_C_TUNE]) begin
            tune_q <= 1'b1;
          end else if (fall[`CIMA_C_TUNE]) begin
            tune_q <= 1'b0;
          end
          ack_q <= fire[`CIMA_C_ACK];
          if (cfg_q[`CIMA_F_PVSW] & cfg_q[`CIMA_F_PV_BY_DI]) begin
            if (rise[`CIMA_C_PV]) begin
              pv2_q <= 1'b1;
            end else if (fall[`CIMA_C_PV]) begin
              pv2_q <= 1'b0;
            end
          end
          if (fire[`CIMA_C_SP_ANY] & group_ok(sp_val_q, sp_cnt)) begin
            sp_q <= sp_val_q;
          end
          // the group in use by a running tuning changes only through these contacts
          if (cfg_q[`CIMA_F_PID_EXT] & fire[`CIMA_C_PID_ANY] & group_ok(pid_val_q, pid_cnt)) begin
            pid_q <= pid_val_q;
          end
        end
      end

      assign cfg_w[n] = cfg_q;
      assign asg_w[n] = asg_q;
      assign sts_w[n] = {16'h0000, pid_q, sp_q, 1'b0, cfg_q[`CIMA_F_EXTERNAL_PV_INPUT], pv2_q, ack_q, tune_q, 1'b0, remote_q, auto_q};
      assign auto_mode_o[n] = auto_q;
      assign remote_sel_o[n] = remote_q;
      assign tune_run_o[n] = tune_q;
      assign alarm_ack_o[n] = ack_q;
      assign second_analog_input_o[n] = pv2_q;
      // external flag relabels both analog inputs as external ones
      assign external_pv_input_o[n] = cfg_q[`CIMA_F_EXTERNAL_PV_INPUT];
      assign setpoint_group_o[n*4 +: 4] = sp_q;
      assign pid_group_o[n*4 +: 4] = pid_q;
    end
  endgenerate
endmodule // cima_top
`default_nettype wire

// *** src/cima_defines.vh ***
// Purpose: constants for the contact-input mode action block
// Assumes: 250 MHz system clock, two control loops
// Notes: register offsets are word indexes (address bits 3:2); the loop stride is in bytes
`ifndef CIMA_DEFINES_VH
`define CIMA_DEFINES_VH
`define CIMA_CLK_PERIOD_NS 4
`define CIMA_CTRL_PERIOD_NS 100000
`define CIMA_CTRL_PERIOD_CYCLES 24'd25000
`define CIMA_NUM_LOOPS 2
`define CIMA_NCONT 16
`define CIMA_NEV 18
// contact positions inside one loop's contact vector
`define CIMA_C_AUTO 0
`define CIMA_C_HAND 1
`define CIMA_C_REMOTE 2
`define CIMA_C_LOCAL 3
`define CIMA_C_AUTOHAND 4
`define CIMA_C_TUNE 5
`define CIMA_C_ACK 6
`define CIMA_C_PV 7
`define CIMA_C_SP_LSB 8
`define CIMA_C_PID_LSB 12
`define CIMA_C_SP_ANY 16
`define CIMA_C_PID_ANY 17
// register offsets inside one loop's window, and window stride
`define CIMA_OFS_CFG 2'h0
`define CIMA_OFS_ASSIGN 2'h1
`define CIMA_OFS_STATUS 2'h2
`define CIMA_LOOP_STRIDE 8'h10
// configuration fields
`define CIMA_F_RSP_EN 0
`define CIMA_F_PVSW 1
`define CIMA_F_PV_BY_DI 2
`define CIMA_F_EXTERNAL_PV_INPUT 3
`define CIMA_F_PID_EXT 4
`define CIMA_F_OPMODE_LSB 5
`define CIMA_F_SP_CNT_LSB 8
`define CIMA_F_PID_CNT_LSB 12
// operation modes of trigger-type actions
`define CIMA_MODE_TRIG 2'h0
`define CIMA_MODE_RISE 2'h1
`define CIMA_MODE_FALL 2'h2
// reset values
`define CIMA_CFG_RST 32'h0000_8800
`define CIMA_ASSIGN_RST 32'h0000_0000
`define CIMA_GROUP_RST 4'h1
`define CIMA_GROUP_MAX 4'h8
`define CIMA_RESP_OKAY 2'h0
`define CIMA_RESP_SLVERR 2'h2
`endif

// *** src/cima_sync.v ***
// Purpose: two-flop synchroniser for a vector of contact pins
// Assumes: bits are independent levels
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module cima_sync #(
  parameter W = 32
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // cima_sync
`default_nettype wire

// *** src/cima_detect.v ***
// Purpose: per-period sampling with rise, fall and held-on detection
// Assumes: tick_i pulses once per control period
// Notes: pulses appear one cycle after the tick and last one cycle
`timescale 1ns/10ps
`default_nettype none
module cima_detect #(
  parameter W = 18
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire tick_i,
  input wire [W-1:0] level_i,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o,
  output wire [W-1:0] trig_o
);
  reg [W-1:0] h0_q;
  reg [W-1:0] h1_q;
  reg [W-1:0] h2_q;
  reg ev_q;
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      h0_q <= {W{1'b0}};
      h1_q <= {W{1'b0}};
      h2_q <= {W{1'b0}};
      ev_q <= 1'b0;
    end else begin
      ev_q <= tick_i;
      if (tick_i) begin
        h0_q <= level_i;
        h1_q <= h0_q;
        h2_q <= h1_q;
      end
    end
  end
  assign rise_o = {W{ev_q}} & h0_q & ~h1_q;
  assign fall_o = {W{ev_q}} & ~h0_q & h1_q;
  // on at two samples in a row means the level outlasted one period
  assign trig_o = {W{ev_q}} & h0_q & h1_q & ~h2_q;
endmodule // cima_detect
`default_nettype wire

// *** verif/cima_props.sv ***
// Purpose: port checks for cima_top
// Assumes: one clock, synchronous active-high reset
// Notes: gap between mode changes counted in helper logic
`timescale 1ns/10ps
`default_nettype none
module cima_chk #(
  parameter [23:0] CTRL_PERIOD_CYCLES = 24'd8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] auto_mode_o,
  input wire logic [1:0] alarm_ack_o,
  input wire logic [7:0] setpoint_group_o,
  input wire logic [7:0] pid_group_o
);
  logic [1:0] auto_q;
  logic [23:0] gap_q;
  logic [23:0] gap_d;
  // saturate so a long idle stretch never wraps into a false gap
  assign gap_d = (auto_mode_o != auto_q) ? 24'h1 : ((gap_q < CTRL_PERIOD_CYCLES) ? gap_q + 24'h1 : gap_q);
  always @(posedge clk_sys_i) begin
    auto_q <= srst_i ? 2'h0 : auto_mode_o;
    gap_q <= srst_i ? CTRL_PERIOD_CYCLES : gap_d;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence ar_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence w_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  reset_state_a: assert property (@(posedge clk_sys_i) disable iff (1'b0) srst_i |=>
    setpoint_group_o == 8'h11 && pid_group_o == 8'h11 && auto_mode_o == 2'h0) else $error("reset state wrong");
  period_gap_a: assert property ((auto_mode_o != auto_q) |-> gap_q >= CTRL_PERIOD_CYCLES)
    else $error("mode changed twice within a period");
  ack_pulse_a: assert property ((alarm_ack_o != 2'h0) |=> alarm_ack_o == 2'h0)
    else $error("acknowledge longer than one cycle");
  sp_range_a: assert property (setpoint_group_o[3:0] inside {[1:8]} && setpoint_group_o[7:4] inside {[1:8]})
    else $error("setpoint group out of range");
  pid_range_a: assert property (pid_group_o[3:0] inside {[1:8]} && pid_group_o[7:4] inside {[1:8]})
    else $error("pid group out of range");
  // both items are parked first, so the response comes one edge after the parked pair is seen
  write_answer_a: assert property (w_taken |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid_o)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
endmodule // cima_chk
bind cima_top cima_chk #(.CTRL_PERIOD_CYCLES(CTRL_PERIOD_CYCLES)) cima_chk_i (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .auto_mode_o(auto_mode_o), .alarm_ack_o(alarm_ack_o),
  .setpoint_group_o(setpoint_group_o), .pid_group_o(pid_group_o));
`default_nettype wire

// *** verif/cima_contact_src.sv ***
// Purpose: field contacts feeding the loop contact pins
// Assumes: bench asks for new levels through want_i
// Notes: a level is held at least HOLD clocks
`timescale 1ns/10ps
`default_nettype none
module cima_contact_src #(
  parameter int HOLD = 16
) (
  input wire logic clk_sys_i,
  input wire logic [31:0] want_i,
  output logic [31:0] loop_contact_o
);
  int cnt_q;
  initial begin
    loop_contact_o = 32'h0;
    cnt_q = 0;
  end
  // two periods of hold, so a trigger is never cut short
  always @(posedge clk_sys_i) begin
    if (cnt_q >= HOLD && want_i != loop_contact_o) begin
      loop_contact_o <= want_i;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule // cima_contact_src
`default_nettype wire

// *** verif/contact_input_mode_actions_tb_top.sv ***
// Purpose: register and contact tests for cima_top
// Assumes: period shortened to 8 clocks
// Notes: each contact step waits four periods
`timescale 1ns/10ps
`default_nettype none
module contact_input_mode_actions_tb_top;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0, want = 32'h0, rdat;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [1:0] resp;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o, auto_mode_o, remote_sel_o, tune_run_o, alarm_ack_o;
  wire [1:0] second_analog_input_o, external_pv_input_o;
  wire [31:0] s_axi_rdata_o, loop_contact_i;
  wire [7:0] setpoint_group_o, pid_group_o;
  int mismatches = 0, n_tests = 0, cyc = 0, acks = 0;
  cima_top #(.CTRL_PERIOD_CYCLES(24'd8)) cima_top_i (.clk_sys_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .loop_contact_i, .auto_mode_o, .remote_sel_o,
    .tune_run_o, .alarm_ack_o, .second_analog_input_o, .external_pv_input_o, .setpoint_group_o, .pid_group_o);
  cima_contact_src cima_contact_src_i (.clk_sys_i(clk_sys_i), .want_i(want), .loop_contact_o(loop_contact_i));
  always #2 clk_sys_i = ~clk_sys_i;
  task close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (alarm_ack_o[0] === 1'b1) acks++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, bv;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ta = s_axi_awready_o;
      tw = s_axi_wready_o;
      bv = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
    end while (!bv);
    s_axi_bready_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic ta, rv;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ta = s_axi_arready_o;
      rv = s_axi_rvalid_o;
      rdat = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
    end while (!rv);
    s_axi_rready_i <= 1'b0;
  endtask
  task put(input logic [31:0] w);
    @(posedge clk_sys_i);
    want <= w;
    repeat (32) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    chk(32'(setpoint_group_o), 32'h11);
    rd(8'h00);
    chk(rdat, 32'h0000_8800);
    rd(8'h20);
    chk(32'(resp), 32'h2);
    chk(rdat, 32'h0);
    wr(8'h00, 32'h0000_6817);
    chk(32'(resp), 32'h0);
    wr(8'h04, 32'h0000_FFFF);
    wr(8'h20, 32'hFFFF_FFFF);
    chk(32'(resp), 32'h2);
    rd(8'h00);
    chk(rdat, 32'h0000_6817);
    $display("test registers done");
    put(32'h1);
    chk(32'(auto_mode_o), 32'h1);
    put(32'h0);
    chk(32'(auto_mode_o), 32'h1);
    put(32'h2);
    chk(32'(auto_mode_o), 32'h0);
    put(32'h0);
    put(32'h10);
    chk(32'(auto_mode_o), 32'h1);
    put(32'h0);
    chk(32'(auto_mode_o), 32'h0);
    put(32'h4);
    chk(32'(remote_sel_o), 32'h1);
    put(32'h0);
    chk(32'(remote_sel_o), 32'h1);
    put(32'h8);
    chk(32'(remote_sel_o), 32'h0);
    put(32'h0);
    put(32'h20);
    chk(32'(tune_run_o), 32'h1);
    put(32'h0);
    chk(32'(tune_run_o), 32'h0);
    put(32'h40);
    put(32'h0);
    chk(32'(acks), 32'h1);
    put(32'h80);
    chk(32'(second_analog_input_o), 32'h1);
    put(32'h0);
    chk(32'(second_analog_input_o), 32'h0);
    $display("test modes done");
    put(32'h500);
    put(32'h0);
    chk(32'(setpoint_group_o), 32'h15);
    rd(8'h08);
    chk(32'(rdat[11:8]), 32'h5);
    put(32'h900);
    put(32'h0);
    chk(32'(setpoint_group_o), 32'h15);
    put(32'h7000);
    put(32'h0);
    chk(32'(pid_group_o), 32'h11);
    put(32'h3000);
    put(32'h0);
    chk(32'(pid_group_o), 32'h13);
    wr(8'h00, 32'h0000_6807);
    put(32'h2000);
    put(32'h0);
    chk(32'(pid_group_o), 32'h13);
    put(32'h0401_0000);
    put(32'h0);
    chk(32'(setpoint_group_o), 32'h15);
    chk(32'(auto_mode_o), 32'h0);
    $display("test groups done");
    wr(8'h00, 32'h0000_6827);
    put(32'h1);
    chk(32'(auto_mode_o), 32'h1);
    put(32'h0);
    wr(8'h00, 32'h0000_6847);
    put(32'h2);
    chk(32'(auto_mode_o), 32'h1);
    put(32'h0);
    chk(32'(auto_mode_o), 32'h0);
    wr(8'h00, 32'h0000_6806);
    put(32'h4);
    chk(32'(remote_sel_o), 32'h0);
    put(32'h0);
    wr(8'h14, 32'h0000_FFFF);
    put(32'h0001_0000);
    chk(32'(auto_mode_o), 32'h2);
    put(32'h0);
    wr(8'h00, 32'h0000_684F);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(external_pv_input_o), 32'h1);
    $display("test operation modes done");
    close_out();
  end
endmodule // contact_input_mode_actions_tb_top
`default_nettype wire
